// >>> shared/bseq_pkg.sv
// Purpose: Constants and types shared by the boot sequencer.
// Assumes: 40 MHz sys_clk; OTP and RAM addressed in 32-bit words.
// Notes: Script command codes and OTP header layout live here.
package bseq_pkg;
   // ==========================================
   // Script commands
   localparam logic [31:0] SCR_START = 32'ha5a5a5a5;
   localparam logic [31:0] SCR_EMPTY = 32'hffffffff;
   localparam logic [31:0] SCR_NO_DEBUG = 32'ha0000000 ^ 32'hd0000000;
   localparam logic [31:0] SCR_SPI_FAST = 32'ha0000000;
   localparam logic [3:0] SCR_NIB_STX = 4'h8;
   localparam logic [3:0] SCR_NIB_SDK = 4'h9;
   localparam int SCR_NIB_LSB = 28;
   localparam int SDK_CNT_LSB = 8;
   localparam int STX_W = 28;
   // ==========================================
   // OTP layout, word addresses
   localparam int OTP_AW = 13;
   localparam logic [12:0] OTP_FLAG0 = 13'h0000;
   localparam logic [12:0] OTP_FLAG1 = 13'h0001;
   localparam logic [12:0] OTP_BOOTCFG = 13'h0002;
   localparam logic [12:0] OTP_SCRIPT = 13'h1e00;
   localparam logic [12:0] OTP_IMAGE = 13'h0000;
   localparam logic [31:0] FLAG0_NORMAL = 32'h1234a5a5;
   localparam logic [31:0] FLAG1_NORMAL = 32'ha5a51234;
   localparam int CFG_ALT_BIT = 0;
   localparam int CFG_UART_LSB = 24;
   localparam logic [7:0] UART_CFG_B = 8'h01;
   localparam logic [7:0] UART_CFG_C = 8'h02;
   // ==========================================
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int BAUD_HZ = 115_200;
   localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_HZ);
   localparam int STX_UNIT_NS = 100_000;
   localparam int STX_UNIT_CYC = STX_UNIT_NS / 1000 * (CLK_HZ / 1_000_000);
   localparam logic [27:0] STX_DEF_UNITS = 28'h0000028;
   // ==========================================
   // Types
   typedef enum logic [5:0] {
      STEP_SPI_MST = 6'h01, STEP_UART1_A = 6'h02, STEP_UART1_B = 6'h04,
      STEP_UART2 = 6'h08, STEP_SPI_SLV = 6'h10, STEP_I2C = 6'h20
   } bseq_step_e_t;
   typedef struct packed {
      logic [5:0] sel;
      logic altPins;
      logic [1:0] uartCfg;
      logic spiFast;
      logic [15:0] baudDiv;
   } bseq_step_t;
   typedef struct packed {
      logic we;
      logic [OTP_AW-1:0] addr;
      logic [31:0] data;
   } bseq_ram_wr_t;
   typedef struct packed {
      logic we;
      logic [31:0] addr;
      logic [31:0] data;
   } bseq_cfg_wr_t;
endpackage

// >>> verilog/bseq_boot_sequencer.sv
// Purpose: Boot sequencer: script, image copy, mode pick, interface scan.
// Assumes: Boot engines and OTP/RAM run on sys_clk; xtal ready is async.
// Notes: Step engines report found/fail; this block owns order and timeouts.
`timescale 1ns/10ps
module bseq_boot_sequencer #(
   parameter int IMAGE_WORDS = 64,
   parameter int SCRIPT_WORDS = 128,
   parameter int STEP_TIMEOUT_CYC = 400_000
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Reset causes
   input wire logic hwResetReq,
   input wire logic wakeEvent,
   input wire logic resetAfterWake,
   // OTP read port
   input wire logic otpOperational,
   output logic otpEnable,
   output logic otpRd,
   output logic [bseq_pkg::OTP_AW-1:0] otpAddr,
   input wire logic otpValid,
   input wire logic [31:0] otpData,
   // RAM and register writes
   output bseq_pkg::bseq_ram_wr_t ramWr,
   output bseq_pkg::bseq_cfg_wr_t cfgWr,
   // Clocks
   output logic fastRcSel,
   output logic fastCrystalEn,
   input wire logic fastCrystalReady,
   // Boot step engines
   output bseq_pkg::bseq_step_t step,
   output logic stepStart,
   input wire logic stepFound,
   input wire logic stepFail,
   // Shared serial line direction
   input wire logic lineTxReq,
   input wire logic lineRxReq,
   output logic lineDirTx,
   output logic lineDirDone,
   // Debug port
   output logic debugEn,
   input wire logic swdOut,
   input wire logic swdOe,
   output logic swdIn,
   input wire logic swdClkOut,
   output logic debugDataOut,
   output logic debugDataOe,
   input wire logic debugDataIn,
   output logic debugClockOut,
   output logic debugClockOe,
   // Status
   output logic scriptEn,
   output logic gpioDefault,
   output logic bootDone,
   output logic devMode
);
   import bseq_pkg::*;

   typedef enum logic [10:0] {
      S_IDLE = 11'h001, S_OTP = 11'h002, S_BAUD = 11'h004, S_SCRIPT = 11'h008,
      S_FLAGS = 11'h010, S_COPY = 11'h020, S_XTAL = 11'h040, S_DEV = 11'h080,
      S_SCAN = 11'h100, S_PARK = 11'h200, S_DONE = 11'h400
   } bseq_state_t;

   bseq_state_t state_r;
   logic [OTP_AW-1:0] idx_r;
   logic [7:0] skip_r;
   logic pendVal_r;
   logic [31:0] holdAddr_r;
   logic noDebug_r;
   logic spiFast_r;
   logic [STX_W-1:0] stx_r;
   logic [31:0] flag0_r;
   logic [31:0] bootCfg_r;
   logic devPath_r;
   logic devPhase_r;
   logic [5:0] scanSel_r;
   logic armed_r;
   logic [39:0] tmr_r;
   logic [2:0] xtalSync_r;
   logic xtalOk_r;
   logic [1:0] uartCfg;
   logic stepOver;
   logic startReq;
   logic isUartStep;

   // ==========================================
   // Start causes
   assign startReq = hwResetReq | (wakeEvent & resetAfterWake);

   // ==========================================
   // Crystal ready synchroniser
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         xtalSync_r <= 3'h0;
         xtalOk_r <= 1'b0;
      end else begin
         xtalSync_r <= {xtalSync_r[1:0], fastCrystalReady};
         if (xtalSync_r[1] == xtalSync_r[2]) begin
            xtalOk_r <= xtalSync_r[2];
         end
      end
   end

   // ==========================================
   // Serial config select
   always_comb begin
      unique case (bootCfg_r[CFG_UART_LSB +: 8])
         UART_CFG_B: uartCfg = 2'h1;
         UART_CFG_C: uartCfg = 2'h2;
         default: uartCfg = 2'h0;
      endcase
   end

   assign isUartStep = (state_r == S_DEV && !devPhase_r) ||
      (|(scanSel_r & (STEP_UART1_A | STEP_UART1_B | STEP_UART2)));

   // ==========================================
   // Step outputs
   always_comb begin
      step.sel = 6'h00;
      step.altPins = 1'b0;
      step.uartCfg = 2'h0;
      step.spiFast = spiFast_r;
      step.baudDiv = BAUD_DIV;
      if (armed_r && state_r == S_DEV) begin
         step.altPins = 1'b1;
         step.sel = devPhase_r ? STEP_SPI_MST : STEP_UART2;
         step.uartCfg = uartCfg;
      end else if (armed_r && state_r == S_SCAN) begin
         step.sel = scanSel_r;
      end
   end

   assign stepOver = armed_r && (stepFail || tmr_r == 40'h0);

   // ==========================================
   // Main sequence
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= S_OTP;
         idx_r <= '0;
         devPath_r <= 1'b0;
         devPhase_r <= 1'b0;
         scanSel_r <= 6'h00;
         armed_r <= 1'b0;
         stepStart <= 1'b0;
         otpEnable <= 1'b1;
         fastCrystalEn <= 1'b0;
         bootDone <= 1'b0;
         gpioDefault <= 1'b0;
      end else begin
         stepStart <= 1'b0;
         gpioDefault <= 1'b0;
         if (startReq) begin
            state_r <= S_OTP;
            idx_r <= '0;
            armed_r <= 1'b0;
            otpEnable <= 1'b1;
            bootDone <= 1'b0;
            fastCrystalEn <= 1'b0;
            scanSel_r <= 6'h00;
         end else begin
            unique case (state_r)
               S_IDLE: begin
               end
               S_OTP: begin
                  if (otpOperational) begin
                     state_r <= S_BAUD;
                  end
               end
               S_BAUD: begin
                  state_r <= S_SCRIPT;
               end
               S_SCRIPT: begin
                  if (otpValid) begin
                     idx_r <= idx_r + 1'b1;
                     if ((idx_r == '0 && otpData != SCR_START) ||
                        (!pendVal_r && skip_r == 8'h00 && otpData == SCR_EMPTY) ||
                        idx_r == OTP_AW'(SCRIPT_WORDS - 1)) begin
                        state_r <= S_FLAGS;
                        idx_r <= '0;
                     end
                  end
               end
               S_FLAGS: begin
                  if (otpValid) begin
                     idx_r <= idx_r + 1'b1;
                     if (idx_r == OTP_AW'(2)) begin
                        state_r <= S_COPY;
                        idx_r <= '0;
                     end
                  end
               end
               S_COPY: begin
                  if (otpValid) begin
                     idx_r <= idx_r + 1'b1;
                     if (idx_r == OTP_AW'(IMAGE_WORDS - 1)) begin
                        state_r <= S_XTAL;
                        fastCrystalEn <= 1'b1;
                        devPath_r <= devMode && bootCfg_r[CFG_ALT_BIT];
                        devPhase_r <= 1'b0;
                     end
                  end
               end
               S_XTAL: begin
                  if (xtalOk_r) begin
                     if (devPath_r) begin
                        state_r <= S_DEV;
                     end else begin
                        state_r <= S_SCAN;
                        otpEnable <= 1'b0;
                        scanSel_r <= STEP_SPI_MST;
                     end
                  end
               end
               S_DEV, S_SCAN: begin
                  if (!armed_r) begin
                     armed_r <= 1'b1;
                     stepStart <= 1'b1;
                  end else if (stepFound) begin
                     armed_r <= 1'b0;
                     state_r <= S_DONE;
                     bootDone <= 1'b1;
                     gpioDefault <= 1'b1;
                  end else if (stepOver) begin
                     armed_r <= 1'b0;
                     if (state_r == S_DEV) begin
                        if (devPhase_r) begin
                           state_r <= S_SCAN;
                           otpEnable <= 1'b0;
                           scanSel_r <= STEP_SPI_MST;
                        end
                        devPhase_r <= 1'b1;
                     end else if (scanSel_r == STEP_I2C) begin
                        if (noDebug_r) begin
                           scanSel_r <= STEP_SPI_MST;
                        end else begin
                           state_r <= S_PARK;
                           scanSel_r <= 6'h00;
                           gpioDefault <= 1'b1;
                        end
                     end else begin
                        scanSel_r <= scanSel_r << 1;
                     end
                  end
               end
               S_PARK: begin
               end
               S_DONE: begin
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // OTP read and image copy
   assign otpRd = state_r == S_SCRIPT || state_r == S_FLAGS || state_r == S_COPY;
   always_comb begin
      unique case (state_r)
         S_SCRIPT: otpAddr = OTP_SCRIPT + idx_r;
         S_FLAGS: otpAddr = OTP_FLAG0 + idx_r;
         default: otpAddr = OTP_IMAGE + idx_r;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ramWr <= '0;
      end else begin
         ramWr.we <= state_r == S_COPY && otpValid;
         ramWr.addr <= idx_r;
         ramWr.data <= otpData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         flag0_r <= 32'h00000000;
         bootCfg_r <= 32'h00000000;
         devMode <= 1'b0;
      end else if (state_r == S_FLAGS && otpValid) begin
         if (idx_r == OTP_AW'(0)) begin
            flag0_r <= otpData;
         end
         if (idx_r == OTP_AW'(1)) begin
            devMode <= !(flag0_r == FLAG0_NORMAL && otpData == FLAG1_NORMAL);
         end
         if (idx_r == OTP_AW'(2)) begin
            bootCfg_r <= otpData;
         end
      end
   end

   // ==========================================
   // Script interpreter
   always_ff @(posedge sys_clk) begin
      if (sys_rst || startReq) begin
         skip_r <= 8'h00;
         pendVal_r <= 1'b0;
         holdAddr_r <= 32'h00000000;
         noDebug_r <= 1'b0;
         spiFast_r <= 1'b0;
         stx_r <= STX_DEF_UNITS;
         cfgWr <= '0;
      end else begin
         cfgWr.we <= 1'b0;
         if (state_r == S_SCRIPT && otpValid && idx_r != '0) begin
            if (skip_r != 8'h00) begin
               skip_r <= skip_r - 1'b1;
            end else if (pendVal_r) begin
               pendVal_r <= 1'b0;
               cfgWr.we <= 1'b1;
               cfgWr.addr <= holdAddr_r;
               cfgWr.data <= otpData;
            end else if (otpData == SCR_EMPTY) begin
            end else if (otpData == SCR_NO_DEBUG) begin
               noDebug_r <= 1'b1;
            end else if (otpData == SCR_SPI_FAST) begin
               spiFast_r <= 1'b1;
            end else if (otpData[SCR_NIB_LSB +: 4] == SCR_NIB_STX) begin
               stx_r <= otpData[STX_W-1:0];
            end else if (otpData[SCR_NIB_LSB +: 4] == SCR_NIB_SDK) begin
               skip_r <= otpData[SDK_CNT_LSB +: 8];
            end else begin
               holdAddr_r <= otpData;
               pendVal_r <= 1'b1;
            end
         end
      end
   end

   // ==========================================
   // Step timeout
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tmr_r <= 40'h0;
      end else if (!armed_r) begin
         if (isUartStep) begin
            tmr_r <= 40'(stx_r) * 40'(STX_UNIT_CYC);
         end else begin
            tmr_r <= 40'(STEP_TIMEOUT_CYC);
         end
      end else if (tmr_r != 40'h0) begin
         tmr_r <= tmr_r - 40'h1;
      end
   end

   // ==========================================
   // Shared line direction
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lineDirTx <= 1'b0;
         lineDirDone <= 1'b0;
      end else begin
         lineDirDone <= lineTxReq | lineRxReq;
         if (lineTxReq) begin
            lineDirTx <= 1'b1;
         end else if (lineRxReq) begin
            lineDirTx <= 1'b0;
         end
      end
   end

   // ==========================================
   // Clock, script enable and debug pins
   assign fastRcSel = 1'b1;
   assign scriptEn = state_r == S_SCRIPT;
   assign debugEn = state_r == S_PARK;
   assign debugDataOut = debugEn & swdOut;
   assign debugDataOe = debugEn & swdOe;
   assign swdIn = debugEn & debugDataIn;
   assign debugClockOut = debugEn & swdClkOut;
   assign debugClockOe = 1'b0;
endmodule

// >>> tb/bseq_boot_monitor.sv
// Purpose: Concurrent checks on the boot sequencer ports.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to every sequencer instance.
`timescale 1ns/10ps
module bseq_boot_monitor #(
   parameter int STEP_TIMEOUT_CYC = 400_000
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Causes and OTP
   input wire logic hwResetReq,
   input wire logic otpValid,
   input wire logic otpEnable,
   input wire bseq_pkg::bseq_ram_wr_t ramWr,
   // Clocks
   input wire logic fastRcSel,
   input wire logic fastCrystalEn,
   // Steps
   input wire bseq_pkg::bseq_step_t step,
   input wire logic stepStart,
   input wire logic stepFound,
   // Line direction
   input wire logic lineTxReq,
   input wire logic lineRxReq,
   input wire logic lineDirTx,
   input wire logic lineDirDone,
   // Debug and status
   input wire logic debugEn,
   input wire logic swdOut,
   input wire logic swdClkOut,
   input wire logic debugDataOut,
   input wire logic debugClockOut,
   input wire logic bootDone,
   input wire logic gpioDefault,
   input wire logic devMode
);
   import bseq_pkg::*;
   int stepCyc;
   // ==========================================
   // Cycles spent in the current step
   always_ff @(posedge sys_clk) begin
      if (sys_rst || stepStart || step.sel == 6'h00) begin
         stepCyc <= 0;
      end else begin
         stepCyc <= stepCyc + 1;
      end
   end
   default clocking mcb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Assertions
   a_rc_clock_kept: assert property (fastRcSel)
      else $error("fast RC select dropped");
   a_xtal_before_step: assert property (stepStart |-> fastCrystalEn)
      else $error("step started without crystal");
   a_otp_off_scan: assert property (stepStart && !devMode |-> !otpEnable)
      else $error("OTP enabled during scan");
   a_tx_dir_set: assert property (lineTxReq |=> lineDirTx && lineDirDone)
      else $error("line not turned to transmit");
   a_rx_dir_set: assert property (lineRxReq && !lineTxReq |=> !lineDirTx && lineDirDone)
      else $error("line not turned to receive");
   a_ram_after_read: assert property (ramWr.we |-> $past(otpValid))
      else $error("RAM write without OTP word");
   a_found_finish: assert property ((|step.sel) && stepFound && !bootDone && !hwResetReq
      |=> bootDone && gpioDefault) else $error("found step did not finish boot");
   a_step_bounded: assert property ((step.sel & 6'h31) != 6'h00 && !bootDone && !debugEn
      |-> stepCyc <= STEP_TIMEOUT_CYC + 4) else $error("step outlived its timeout");
   a_start_follows: assert property ($rose(|step.sel) |-> stepStart)
      else $error("no start after step select");
   a_park_debug: assert property (debugEn |-> debugDataOut == swdOut && debugClockOut == swdClkOut)
      else $error("debug pins not routed");
   a_hw_restart: assert property (hwResetReq |=> !bootDone && !debugEn && step.sel == 6'h00)
      else $error("hardware reset did not restart");
endmodule

bind bseq_boot_sequencer bseq_boot_monitor #(.STEP_TIMEOUT_CYC(STEP_TIMEOUT_CYC)) uMon (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .hwResetReq(hwResetReq), .otpValid(otpValid),
   .otpEnable(otpEnable), .ramWr(ramWr), .fastRcSel(fastRcSel), .fastCrystalEn(fastCrystalEn),
   .step(step), .stepStart(stepStart), .stepFound(stepFound), .lineTxReq(lineTxReq),
   .lineRxReq(lineRxReq), .lineDirTx(lineDirTx), .lineDirDone(lineDirDone), .debugEn(debugEn),
   .swdOut(swdOut), .swdClkOut(swdClkOut), .debugDataOut(debugDataOut),
   .debugClockOut(debugClockOut), .bootDone(bootDone), .gpioDefault(gpioDefault),
   .devMode(devMode)
);

// >>> tb/bseq_otp_model.sv
// Purpose: OTP read port model.
// Assumes: Address held until otpValid.
// Notes: Bench fills mem; slow adds wait cycles.
`timescale 1ns/10ps
module bseq_otp_model (
   // Clock
   input wire logic sys_clk,
   // Read port
   input wire logic otpEnable,
   input wire logic otpRd,
   input wire logic [bseq_pkg::OTP_AW-1:0] otpAddr,
   output logic otpValid,
   output logic [31:0] otpData,
   // Pace
   input wire logic slow
);
   logic [31:0] mem [0:8191];
   int gap = 0;
   // ==========================================
   // One word per read, data scrambled outside the valid cycle
   always @(posedge sys_clk) begin
      if (gap == 0 && otpRd && otpEnable) begin
         otpValid <= #2 1'b1;
         otpData <= #2 mem[otpAddr];
         gap <= slow ? 4 : 2;
      end else begin
         otpValid <= #2 1'b0;
         otpData <= #2 ~otpData;
         if (gap > 0) begin
            gap <= gap - 1;
         end
      end
   end
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the boot sequencer.
// Assumes: OTP model answers reads; the bench plays the step engines.
// Notes: Short step timeout and image keep the run brief.
`timescale 1ns/10ps
module testbench;
   import bseq_pkg::*;
   localparam int TMO = 50;
   localparam int IMW = 8;
   logic sys_clk = 0, sys_rst = 1, hwResetReq = 0, wakeEvent = 0, resetAfterWake = 0;
   logic otpOperational = 0, otpEnable, otpRd, otpValid, slow = 0;
   logic [OTP_AW-1:0] otpAddr;
   logic [31:0] otpData;
   bseq_ram_wr_t ramWr;
   bseq_cfg_wr_t cfgWr;
   bseq_step_t step;
   logic fastRcSel, fastCrystalEn, fastCrystalReady = 0, stepStart, stepFound = 0, stepFail = 0;
   logic lineTxReq = 0, lineRxReq = 0, lineDirTx, lineDirDone, debugEn, swdOut = 0, swdOe = 0;
   logic swdIn, swdClkOut = 0, debugDataOut, debugDataOe, debugDataIn = 0, debugClockOut;
   logic debugClockOe, scriptEn, gpioDefault, bootDone, devMode, tx;
   logic [4:0] m;
   logic [3:0] dbg;
   int fails = 0, checked = 0, cyc = 0, ramIdx = 0, seed = 32'hcfe0397e;
   logic [31:0] scr[$];
   bseq_cfg_wr_t gotCfg[$];

   bseq_boot_sequencer #(.IMAGE_WORDS(IMW), .STEP_TIMEOUT_CYC(TMO)) uut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .hwResetReq(hwResetReq), .wakeEvent(wakeEvent),
      .resetAfterWake(resetAfterWake), .otpOperational(otpOperational), .otpEnable(otpEnable),
      .otpRd(otpRd), .otpAddr(otpAddr), .otpValid(otpValid), .otpData(otpData), .ramWr(ramWr),
      .cfgWr(cfgWr), .fastRcSel(fastRcSel), .fastCrystalEn(fastCrystalEn),
      .fastCrystalReady(fastCrystalReady), .step(step), .stepStart(stepStart),
      .stepFound(stepFound), .stepFail(stepFail), .lineTxReq(lineTxReq), .lineRxReq(lineRxReq),
      .lineDirTx(lineDirTx), .lineDirDone(lineDirDone), .debugEn(debugEn), .swdOut(swdOut),
      .swdOe(swdOe), .swdIn(swdIn), .swdClkOut(swdClkOut), .debugDataOut(debugDataOut),
      .debugDataOe(debugDataOe), .debugDataIn(debugDataIn), .debugClockOut(debugClockOut),
      .debugClockOe(debugClockOe), .scriptEn(scriptEn), .gpioDefault(gpioDefault),
      .bootDone(bootDone), .devMode(devMode)
   );
   bseq_otp_model otp (.sys_clk(sys_clk), .otpEnable(otpEnable), .otpRd(otpRd),
      .otpAddr(otpAddr), .otpValid(otpValid), .otpData(otpData), .slow(slow));

   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) fastCrystalReady <= #2 fastCrystalEn;
   // ==========================================
   // Capture of script and image writes
   always @(posedge sys_clk) begin
      if (!sys_rst && cfgWr.we) gotCfg.push_back(cfgWr);
      if (!sys_rst && ramWr.we) begin
         check("ram addr", ramWr.addr, ramIdx);
         check("ram data", ramWr.data, otp.mem[OTP_IMAGE + ramIdx]);
         ramIdx++;
      end
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict;
      end
   end

   task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask

   task automatic give_verdict;
      $display("Counts: checked %0d, fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic boot(input logic [31:0] f0, input logic [31:0] f1, input logic [31:0] bc);
      int n;
      sys_rst = 1;
      otpOperational = 0;
      slow = 1'($random(seed));
      otp.mem[OTP_FLAG0] = f0;
      otp.mem[OTP_FLAG1] = f1;
      otp.mem[OTP_BOOTCFG] = bc;
      for (int i = 3; i < IMW; i++) otp.mem[OTP_IMAGE + i] = $random(seed);
      for (int i = 0; i < scr.size(); i++) otp.mem[OTP_SCRIPT + i] = scr[i];
      gotCfg.delete();
      ramIdx = 0;
      tick(4);
      sys_rst = 0;
      tick(3);
      check("script early", scriptEn, 1'b0);
      otpOperational = 1;
      n = 0;
      while (scriptEn !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      check("baud", step.baudDiv, BAUD_DIV);
   endtask

   // Expected script writes and mode at the first step
   task automatic head(input logic dev);
      int i, n;
      bseq_cfg_wr_t e;
      n = 0;
      while (stepStart !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      i = (scr[0] == SCR_START) ? 1 : scr.size();
      while (i < scr.size() && scr[i] != SCR_EMPTY) begin
         if (scr[i][31:28] == SCR_NIB_SDK) begin
            i += 1 + scr[i][15:8];
         end else if (scr[i][31:28] == SCR_NIB_STX || scr[i] == SCR_SPI_FAST
               || scr[i] == SCR_NO_DEBUG) begin
            i++;
         end else begin
            e = '{1'b1, scr[i], scr[i + 1]};
            check("cfg write", gotCfg.pop_front(), e);
            i += 2;
         end
      end
      check("cfg count", gotCfg.size(), 0);
      check("ram words", ramIdx, IMW);
      check("dev mode", devMode, dev);
      if (!dev) check("otp off", otpEnable, 1'b0);
   endtask

   // act: 0 fail, 1 found, 2 let the timer run out
   task automatic do_step(input logic [5:0] sel, input int act, input logic [4:0] md, int tmo);
      int n;
      n = 0;
      while (stepStart !== 1'b1 && n < 9000) begin
         tick(1);
         n++;
      end
      check("step sel", step.sel, sel);
      if (md[4]) check("step mode", {step.altPins, step.uartCfg, step.spiFast}, md[3:0]);
      stepFail = (act == 0);
      stepFound = (act == 1);
      tick(1);
      stepFail = 0;
      stepFound = 0;
      if (act == 1 || debugEn === 1'b1) begin
         check("boot done", {bootDone | debugEn, gpioDefault}, 2'b11);
      end
      n = 0;
      while (act == 2 && step.sel !== 6'h00 && n < 9000) begin
         tick(1);
         n++;
      end
      if (act == 2) check("step time", n >= tmo - 3 && n <= tmo + 3, 1'b1);
      tick(1);
   endtask

   initial begin
      scr = '{SCR_START, 32'h80000001, 32'h10000010, $random(seed), 32'h90000101,
         $random(seed), 32'h10000020, $random(seed), SCR_EMPTY, 32'h10000030, 32'h55};
      boot(FLAG0_NORMAL, FLAG1_NORMAL, 32'h0);
      head(1'b0);
      do_step(6'h01, 2, 5'h0, TMO);
      for (int k = 1; k < 4; k++) do_step(6'(1 << k), 0, 5'h0, 0);
      do_step(6'h10, 1, 5'h0, 0);
      repeat (12) begin
         tx = 1'($random(seed));
         lineTxReq = tx;
         lineRxReq = !tx;
         tick(1);
         lineTxReq = 0;
         lineRxReq = 0;
         check("line dir", {lineDirDone, lineDirTx}, {1'b1, tx});
         tick(1);
      end
      $display("Test normal scan done");
      for (int k = 0; k < 3; k++) begin
         scr = '{SCR_START, 32'h80000001, SCR_SPI_FAST, SCR_EMPTY};
         boot(32'h0, FLAG1_NORMAL, {(k == 2) ? 8'h37 : 8'(k + 1), 23'h0, 1'b1});
         m = {2'b11, (k == 2) ? 2'd0 : 2'(k + 1), 1'b1};
         head(1'b1);
         do_step(STEP_UART2, (k == 0) ? 2 : 0, m, STX_UNIT_CYC);
         do_step(STEP_SPI_MST, 0, m, 0);
         do_step(STEP_SPI_MST, 0, 5'h0, 0);
         do_step(STEP_UART1_A, 1, 5'h0, 0);
      end
      $display("Test development path done");
      scr = '{SCR_START, 32'h80000001, SCR_NO_DEBUG, SCR_EMPTY};
      boot(FLAG0_NORMAL, FLAG1_NORMAL, 32'h1);
      head(1'b0);
      for (int k = 0; k < 7; k++) do_step(6'(1 << (k % 6)), 0, 5'h0, 0);
      hwResetReq = 1;
      ramIdx = 0;
      tick(1);
      hwResetReq = 0;
      tick(2);
      head(1'b0);
      do_step(6'h01, 1, 5'h0, 0);
      $display("Test rescan and restart done");
      scr = '{32'h5a5a5a5a, SCR_NO_DEBUG, SCR_EMPTY};
      boot(32'h0, FLAG1_NORMAL, 32'h0);
      head(1'b1);
      for (int k = 0; k < 6; k++) do_step(6'(1 << k), 0, 5'h0, 0);
      tick(4);
      check("parked", debugEn, 1'b1);
      repeat (8) begin
         dbg = 4'($random(seed));
         {swdOut, swdOe, swdClkOut, debugDataIn} = dbg;
         #1;
         check("debug pins", {debugDataOut, debugDataOe, debugClockOut, swdIn}, dbg);
         check("debug clock oe", debugClockOe, 1'b0);
         tick(1);
      end
      wakeEvent = 1;
      tick(1);
      wakeEvent = 0;
      tick(2);
      check("wake ignored", debugEn, 1'b1);
      resetAfterWake = 1;
      wakeEvent = 1;
      ramIdx = 0;
      tick(1);
      wakeEvent = 0;
      tick(2);
      check("wake restart", debugEn, 1'b0);
      $display("Test park and wake done");
      give_verdict;
   end
endmodule
